//--- design/rdl_data_receiver_delay_regs.sv
// Data receiver delay registers, edge search/track controller and serial port
//
// Operation
// - Enabled: sample delay code is search start, limited to 384.
// - Disabled: programmed sample and strobe codes, limited to 384, drive the delay lines directly.
// - Strobe code, split over two registers, sets strobe search start, limit 384.
// - Four-bit window field sets early/late strobe clock separation, reset 1.
// - Read-only registers report delays chosen once tracking is entered.
// - After lock, reported sample and strobe delays come from lines stepped together from their own start codes.
// - Status bit 3 set while tracking established.
// - Status bit 2 set while edge search runs.
// - Status bit 1 set once controller has lost lock.
// - Status bit 0 set while controller is locked.
// - Enable bit selects search/track operation or fixed delays.
// - Auto-relock: raise interrupt on lock loss and restart search.
`timescale 1ns/100ps
module rdl_data_receiver_delay_regs
  import rdl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  input wire logic i_strobe_clk,
  input wire logic i_strobe_early,
  input wire logic i_strobe_late,
  output logic [9:0] o_sample_delay,
  output logic [9:0] o_strobe_delay,
  output logic [3:0] o_early_late_window,
  output logic o_relock_irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [9:0] clamp_code(input logic [9:0] code);
    clamp_code = (code > DELAY_MAX) ? DELAY_MAX : code;
  endfunction : clamp_code

  function automatic logic [7:0] low_byte(input logic [9:0] code);
    low_byte = {code[1:0], 6'h00};
  endfunction : low_byte

  // One step per line; a line at either end stops instead of wrapping
  function automatic logic [9:0] step_code(input logic [9:0] code, input logic up);
    if (up) begin
      step_code = (code < DELAY_MAX) ? code + 10'h001 : code;
    end else begin
      step_code = (code != 10'h000) ? code - 10'h001 : code;
    end
  endfunction : step_code

  // ----------------------------------------
  // Link domain: capture phase samples
  // ----------------------------------------
  // Held pair stays stable for eight strobe cycles, so the toggle is the only signal needing synchronisers
  logic lrst_m_reg, lrst_s_reg;
  rdl_phase_s ph_cap_reg, ph_cap_next;
  rdl_phase_s ph_hold_reg, ph_hold_next;
  logic [2:0] lcnt_reg, lcnt_next;
  logic ltog_reg, ltog_next;

  always_comb begin
    ph_cap_next = '{early: i_strobe_early, late: i_strobe_late};
    lcnt_next = lcnt_reg + 3'h1;
    ph_hold_next = ph_hold_reg;
    ltog_next = ltog_reg;
    if (lcnt_reg == LINK_SAMPLE_LAST) begin
      ph_hold_next = ph_cap_reg;
      ltog_next = ~ltog_reg;
    end
    if (lrst_s_reg) begin
      lcnt_next = 3'h0;
      ph_hold_next = '0;
      ltog_next = 1'b0;
    end
  end

  always_ff @(posedge i_strobe_clk) begin
    lrst_m_reg <= i_rst;
    lrst_s_reg <= lrst_m_reg;
    ph_cap_reg <= ph_cap_next;
    ph_hold_reg <= ph_hold_next;
    lcnt_reg <= lcnt_next;
    ltog_reg <= ltog_next;
  end

  // ----------------------------------------
  // Synchronisers into i_clk
  // ----------------------------------------
  // Order: sclk, cs_n, sdi, link toggle
  logic [3:0] sync_m_reg, sync_s_reg, sync_d_reg;
  logic [3:0] sync_m_next, sync_s_next, sync_d_next;

  always_comb begin
    sync_m_next = {i_spi_sclk, i_spi_cs_n, i_spi_sdi, ltog_reg};
    sync_s_next = sync_m_reg;
    sync_d_next = sync_s_reg;
    if (i_rst) begin
      sync_m_next = 4'h4;
      sync_s_next = 4'h4;
      sync_d_next = 4'h4;
    end
  end

  always_ff @(posedge i_clk) begin
    sync_m_reg <= sync_m_next;
    sync_s_reg <= sync_s_next;
    sync_d_reg <= sync_d_next;
  end

  logic sclk_rise, sclk_fall, cs_n_s, sdi_s, sample_evt;
  assign sclk_rise = sync_s_reg[3] & ~sync_d_reg[3];
  assign sclk_fall = ~sync_s_reg[3] & sync_d_reg[3];
  assign cs_n_s = sync_s_reg[2];
  assign sdi_s = sync_s_reg[1];
  assign sample_evt = sync_s_reg[0] ^ sync_d_reg[0];

  // ----------------------------------------
  // Serial port: 1 r/w bit, 7 address bits, 8 data bits
  // ----------------------------------------
  logic [3:0] bcnt_reg, bcnt_next;
  logic [14:0] sh_reg, sh_next;
  logic [7:0] rd_sh_reg, rd_sh_next;
  logic is_rd_reg, is_rd_next;
  logic sdo_reg, sdo_next;
  logic sdo_oe_reg, sdo_oe_next;
  logic frame_done_reg, frame_done_next;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [6:0] rd_addr;

  always_comb begin
    bcnt_next = bcnt_reg;
    sh_next = sh_reg;
    rd_sh_next = rd_sh_reg;
    is_rd_next = is_rd_reg;
    sdo_next = sdo_reg;
    sdo_oe_next = sdo_oe_reg;
    frame_done_next = frame_done_reg;
    wr_en = 1'b0;
    wr_addr = sh_reg[13:7];
    wr_data = {sh_reg[6:0], sdi_s};
    rd_addr = {sh_reg[5:0], sdi_s};
    if (cs_n_s) begin
      bcnt_next = 4'h0;
      sdo_oe_next = 1'b0;
      sdo_next = 1'b0;
      frame_done_next = 1'b0;
    end else if (sclk_rise && !frame_done_reg) begin
      sh_next = {sh_reg[13:0], sdi_s};
      bcnt_next = bcnt_reg + 4'h1;
      if (bcnt_reg == SPI_INSTR_LAST) begin
        is_rd_next = sh_reg[6];
        rd_sh_next = rd_data;
      end
      if (bcnt_reg == SPI_FRAME_LAST) begin
        // Extra clocks after a full frame are ignored until chip select rises
        frame_done_next = 1'b1;
        wr_en = ~sh_reg[14];
      end
    end else if (sclk_fall && is_rd_reg && (bcnt_reg > SPI_INSTR_LAST || frame_done_reg)) begin
      sdo_oe_next = ~frame_done_reg;
      sdo_next = rd_sh_reg[7];
      rd_sh_next = {rd_sh_reg[6:0], 1'b0};
    end
    if (i_rst) begin
      bcnt_next = 4'h0;
      sh_next = '0;
      rd_sh_next = 8'h00;
      is_rd_next = 1'b0;
      sdo_next = 1'b0;
      sdo_oe_next = 1'b0;
      frame_done_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    bcnt_reg <= bcnt_next;
    sh_reg <= sh_next;
    rd_sh_reg <= rd_sh_next;
    is_rd_reg <= is_rd_next;
    sdo_reg <= sdo_next;
    sdo_oe_reg <= sdo_oe_next;
    frame_done_reg <= frame_done_next;
  end

  assign o_spi_sdo = sdo_reg;
  assign o_spi_sdo_oe = sdo_oe_reg;

  // ----------------------------------------
  // Registers and search/track controller
  // ----------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] smp_lo_reg, smp_lo_next;
  logic [7:0] smp_hi_reg, smp_hi_next;
  logic [7:0] stb_lo_reg, stb_lo_next;
  logic [7:0] stb_hi_reg, stb_hi_next;
  logic [9:0] act_smp_reg, act_smp_next;
  logic [9:0] act_stb_reg, act_stb_next;
  logic [9:0] smp_dly_reg, smp_dly_next;
  logic [9:0] stb_dly_reg, stb_dly_next;
  logic [2:0] miss_reg, miss_next;
  logic irq_reg, irq_next;
  rdl_flags_s flg_reg, flg_next;
  rdl_state_e st_reg, st_next;
  logic [9:0] smp_code, stb_code;
  logic flg_clr;

  assign smp_code = {smp_hi_reg, smp_lo_reg[7:6]};
  assign stb_code = {stb_hi_reg[5:0], stb_lo_reg[7:4]};

  always_comb begin
    unique case (rd_addr)
      ADDR_CTRL: rd_data = {5'h00, 1'b0, ctrl_reg[1:0]};
      ADDR_SMP_LO: rd_data = {smp_lo_reg[7:6], 6'h00};
      ADDR_SMP_HI: rd_data = smp_hi_reg;
      ADDR_STB_LO_WIN: rd_data = stb_lo_reg;
      ADDR_STB_HI: rd_data = {2'h0, stb_hi_reg[5:0]};
      // Actual delay readback
      ADDR_ACT_SMP_LO: rd_data = low_byte(act_smp_reg);
      ADDR_ACT_SMP_HI: rd_data = act_smp_reg[9:2];
      ADDR_ACT_STB_LO: rd_data = low_byte(act_stb_reg);
      ADDR_ACT_STB_HI: rd_data = act_stb_reg[9:2];
      ADDR_LOCK_STAT: rd_data = {4'h0, flg_reg};
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    smp_lo_next = smp_lo_reg;
    smp_hi_next = smp_hi_reg;
    stb_lo_next = stb_lo_reg;
    stb_hi_next = stb_hi_reg;
    act_smp_next = act_smp_reg;
    act_stb_next = act_stb_reg;
    smp_dly_next = smp_dly_reg;
    stb_dly_next = stb_dly_reg;
    miss_next = miss_reg;
    flg_next = flg_reg;
    st_next = st_reg;
    if (wr_en) begin
      unique case (wr_addr)
        ADDR_CTRL: ctrl_next = {5'h00, wr_data[2:0]};
        ADDR_SMP_LO: smp_lo_next = {wr_data[7:6], 6'h00};
        ADDR_SMP_HI: smp_hi_next = wr_data;
        ADDR_STB_LO_WIN: stb_lo_next = wr_data;
        ADDR_STB_HI: stb_hi_next = {2'h0, wr_data[5:0]};
        default: ;
      endcase
    end
    // Flag reset takes effect on the write of 0 that follows a 1
    flg_clr = ctrl_reg[CTRL_FLGRST_BIT] & ~ctrl_next[CTRL_FLGRST_BIT];
    if (flg_clr) begin
      flg_next.lst = 1'b0;
    end
    unique case (st_reg)
      RDL_IDLE: begin
        smp_dly_next = clamp_code(smp_code);
        stb_dly_next = clamp_code(stb_code);
        flg_next = '0;
        act_smp_next = 10'h000;
        act_stb_next = 10'h000;
        if (ctrl_reg[CTRL_ENA_BIT]) begin
          st_next = RDL_SEARCH;
          // Sample code is the start point
          // Strobe code is the start point
          smp_dly_next = clamp_code(smp_code);
          stb_dly_next = clamp_code(stb_code);
          flg_next.fe = 1'b1;
        end
      end
      RDL_SEARCH: begin
        flg_next.fe = 1'b1;
        if (sample_evt) begin
          if (ph_hold_reg.early && !ph_hold_reg.late) begin
            // Report chosen delays on entering track
            st_next = RDL_TRACK;
            act_smp_next = smp_dly_reg;
            act_stb_next = stb_dly_reg;
            flg_next.fe = 1'b0;
            flg_next.trk = 1'b1;
            flg_next.lck = 1'b1;
            miss_next = 3'h0;
          end else begin
            stb_dly_next = step_code(stb_dly_reg, ph_hold_reg.early);
            smp_dly_next = step_code(smp_dly_reg, ph_hold_reg.early);
          end
        end
      end
      RDL_TRACK: begin
        if (sample_evt) begin
          if (ph_hold_reg.early && !ph_hold_reg.late) begin
            miss_next = 3'h0;
          end else if (miss_reg == LOST_LIMIT - 3'h1) begin
            flg_next.lst = 1'b1;
            flg_next.lck = 1'b0;
            flg_next.trk = 1'b0;
            miss_next = 3'h0;
            st_next = RDL_HOLD;
            if (ctrl_reg[CTRL_LOOP_BIT]) begin
              st_next = RDL_SEARCH;
              smp_dly_next = clamp_code(smp_code);
              stb_dly_next = clamp_code(stb_code);
              flg_next.fe = 1'b1;
            end
          end else begin
            miss_next = miss_reg + 3'h1;
            stb_dly_next = step_code(stb_dly_reg, ph_hold_reg.early);
            smp_dly_next = step_code(smp_dly_reg, ph_hold_reg.early);
            act_smp_next = smp_dly_next;
            act_stb_next = stb_dly_next;
          end
        end
      end
      RDL_HOLD: begin
        // Without auto-relock the delays freeze until the enable is cycled
        if (ctrl_reg[CTRL_LOOP_BIT]) begin
          st_next = RDL_SEARCH;
          smp_dly_next = clamp_code(smp_code);
          stb_dly_next = clamp_code(stb_code);
          flg_next.fe = 1'b1;
        end
      end
    endcase
    if (!ctrl_reg[CTRL_ENA_BIT] && st_reg != RDL_IDLE) begin
      st_next = RDL_IDLE;
      flg_next = '0;
      act_smp_next = 10'h000;
      act_stb_next = 10'h000;
    end
    // Interrupt while lock is lost with auto-relock on
    irq_next = flg_next.lst & ctrl_reg[CTRL_LOOP_BIT];
    if (i_rst) begin
      ctrl_next = CTRL_RST;
      smp_lo_next = SMP_LO_RST;
      smp_hi_next = SMP_HI_RST;
      stb_lo_next = STB_LO_WIN_RST;
      stb_hi_next = STB_HI_RST;
      act_smp_next = 10'h000;
      act_stb_next = 10'h000;
      smp_dly_next = 10'h000;
      stb_dly_next = 10'h000;
      miss_next = 3'h0;
      flg_next = '0;
      st_next = RDL_IDLE;
      irq_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    ctrl_reg <= ctrl_next;
    smp_lo_reg <= smp_lo_next;
    smp_hi_reg <= smp_hi_next;
    stb_lo_reg <= stb_lo_next;
    stb_hi_reg <= stb_hi_next;
    act_smp_reg <= act_smp_next;
    act_stb_reg <= act_stb_next;
    smp_dly_reg <= smp_dly_next;
    stb_dly_reg <= stb_dly_next;
    miss_reg <= miss_next;
    irq_reg <= irq_next;
    flg_reg <= flg_next;
    st_reg <= st_next;
  end

  assign o_sample_delay = smp_dly_reg;
  assign o_strobe_delay = stb_dly_reg;
  assign o_early_late_window = stb_lo_reg[3:0];
  assign o_relock_irq = irq_reg;

endmodule : rdl_data_receiver_delay_regs

//--- design/rdl_pkg.sv
// Constants and types for the data receiver delay register bank
package rdl_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [6:0] ADDR_CTRL = 7'h10;
  localparam logic [6:0] ADDR_SMP_LO = 7'h11;
  localparam logic [6:0] ADDR_SMP_HI = 7'h12;
  localparam logic [6:0] ADDR_STB_LO_WIN = 7'h13;
  localparam logic [6:0] ADDR_STB_HI = 7'h14;
  localparam logic [6:0] ADDR_ACT_SMP_LO = 7'h19;
  localparam logic [6:0] ADDR_ACT_SMP_HI = 7'h1A;
  localparam logic [6:0] ADDR_ACT_STB_LO = 7'h1B;
  localparam logic [6:0] ADDR_ACT_STB_HI = 7'h1C;
  localparam logic [6:0] ADDR_LOCK_STAT = 7'h21;

  // ----------------------------------------
  // Reset values (delay codes start at 167)
  // ----------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h02;
  localparam logic [7:0] SMP_LO_RST = 8'hC0;
  localparam logic [7:0] SMP_HI_RST = 8'h29;
  localparam logic [7:0] STB_LO_WIN_RST = 8'h71;
  localparam logic [7:0] STB_HI_RST = 8'h0A;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_ENA_BIT = 0;
  localparam int CTRL_LOOP_BIT = 1;
  localparam int CTRL_FLGRST_BIT = 2;
  localparam int STAT_LCK_BIT = 0;
  localparam int STAT_LST_BIT = 1;
  localparam int STAT_FE_BIT = 2;
  localparam int STAT_TRK_BIT = 3;

  // ----------------------------------------
  // Limits and counts
  // ----------------------------------------
  localparam logic [9:0] DELAY_MAX = 10'h180;
  localparam logic [2:0] LOST_LIMIT = 3'h4;
  localparam logic [2:0] LINK_SAMPLE_LAST = 3'h7;
  localparam logic [3:0] SPI_INSTR_LAST = 4'h7;
  localparam logic [3:0] SPI_FRAME_LAST = 4'hF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {RDL_IDLE, RDL_SEARCH, RDL_TRACK, RDL_HOLD} rdl_state_e;

  typedef struct packed {
    logic early;
    logic late;
  } rdl_phase_s;

  typedef struct packed {
    logic trk;
    logic fe;
    logic lst;
    logic lck;
  } rdl_flags_s;

endpackage : rdl_pkg

//--- tb/rdl_data_receiver_delay_regs_properties.sv
// Port-level assertions for the delay register bank
`timescale 1ns/100ps
module rdl_data_receiver_delay_regs_properties
  import rdl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sdi,
  input wire logic o_spi_sdo,
  input wire logic o_spi_sdo_oe,
  input wire logic i_strobe_clk,
  input wire logic i_strobe_early,
  input wire logic i_strobe_late,
  input wire logic [9:0] o_sample_delay,
  input wire logic [9:0] o_strobe_delay,
  input wire logic [3:0] o_early_late_window,
  input wire logic o_relock_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_state: assert property ($fell(i_rst) |-> o_sample_delay == 10'h000 &&
    o_strobe_delay == 10'h000 && o_early_late_window == 4'h1 && !o_relock_irq && !o_spi_sdo_oe)
    else $error("outputs wrong after reset");
  a_sample_limit: assert property (o_sample_delay <= DELAY_MAX)
    else $error("sample delay above limit");
  a_strobe_limit: assert property (o_strobe_delay <= DELAY_MAX)
    else $error("strobe delay above limit");
  a_relock_equal: assert property (o_relock_irq |-> o_sample_delay == o_strobe_delay)
    else $error("delay lines differ during relock");
  // Delays only move on a link sample or a register write
  a_delay_hold: assert property ((i_spi_cs_n && $stable(i_strobe_clk))[*8] |=>
    $stable(o_sample_delay) && $stable(o_strobe_delay))
    else $error("delay moved without cause");
  a_window_hold: assert property (i_spi_cs_n[*8] |=> $stable(o_early_late_window))
    else $error("window moved without a write");
  a_oe_release: assert property (i_spi_cs_n[*5] |-> !o_spi_sdo_oe)
    else $error("sdo driven outside a frame");
  a_oe_frame: assert property ($rose(o_spi_sdo_oe) |-> !i_spi_cs_n)
    else $error("sdo enabled without select");
  a_sdo_hold: assert property (i_spi_sclk[*4] |=> $stable(o_spi_sdo) && $stable(o_spi_sdo_oe))
    else $error("sdo changed in clock high phase");
endmodule : rdl_data_receiver_delay_regs_properties

bind rdl_data_receiver_delay_regs rdl_data_receiver_delay_regs_properties i_rdl_data_receiver_delay_regs_properties (
  .i_clk, .i_rst, .i_spi_sclk, .i_spi_cs_n, .i_spi_sdi, .o_spi_sdo, .o_spi_sdo_oe, .i_strobe_clk,
  .i_strobe_early, .i_strobe_late, .o_sample_delay, .o_strobe_delay, .o_early_late_window, .o_relock_irq);

//--- tb/rdl_link_model.sv
// Host-side link model: strobe clock and early/late phase samples
`timescale 1ns/100ps
module rdl_link_model (
  input wire logic i_run,
  input wire logic [1:0] i_mode,
  output logic o_strobe_clk,
  output logic o_early,
  output logic o_late
);
  // Clock stands low while stopped; odd start offset keeps it unrelated to the system clock
  initial begin
    o_strobe_clk = 1'b0;
    o_early = 1'b0;
    o_late = 1'b0;
    #7;
    forever begin
      if (i_run) begin
        #16 o_strobe_clk = 1'b1;
        #16 o_strobe_clk = 1'b0;
        o_early = (i_mode != 2'h0);
        o_late = (i_mode == 2'h1);
      end else begin
        #1;
      end
    end
  end
endmodule : rdl_link_model

//--- tb/rdl_data_receiver_delay_regs_tb_top.sv
// Self-checking bench for the delay register bank
`timescale 1ns/100ps
module rdl_data_receiver_delay_regs_tb_top
  import rdl_pkg::*;
;
  logic i_clk, i_rst, sclk, cs_n, sdi, sdo, sdo_oe, stb_clk, early, late, irq, run;
  logic [1:0] mode;
  logic [9:0] smp, stb, held;
  logic [3:0] win;
  logic [7:0] rv;
  int err_count = 0;
  int cmp_count = 0;

  rdl_data_receiver_delay_regs i_rdl_data_receiver_delay_regs (.i_clk(i_clk), .i_rst(i_rst),
    .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe),
    .i_strobe_clk(stb_clk), .i_strobe_early(early), .i_strobe_late(late), .o_sample_delay(smp),
    .o_strobe_delay(stb), .o_early_late_window(win), .o_relock_irq(irq));
  rdl_link_model i_rdl_link_model (.i_run(run), .i_mode(mode), .o_strobe_clk(stb_clk),
    .o_early(early), .o_late(late));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_val(input string n, input logic [9:0] e, input logic [9:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %b got %b", n, e, g);
    end
  endtask : chk_bit
  // Serial clock kept at 200 ns so the two-stage synchroniser sees every phase
  task automatic spi(input logic r, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {r, a, d};
    q = 8'h00;
    cs_n = 1'b0;
    repeat (3) @(negedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      repeat (5) @(negedge i_clk);
      if (i < 8) q[i] = sdo;
      sclk = 1'b1;
      repeat (5) @(negedge i_clk);
      sclk = 1'b0;
    end
    repeat (5) @(negedge i_clk);
    cs_n = 1'b1;
    repeat (10) @(negedge i_clk);
  endtask : spi
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi(1'b0, a, d, rv);
  endtask : wr
  task automatic rd_chk(input string n, input logic [6:0] a, input logic [7:0] e);
    spi(1'b1, a, 8'h00, rv);
    chk_val(n, {2'h0, e}, {2'h0, rv});
  endtask : rd_chk
  task automatic wait_stat(input logic [7:0] e);
    rv = ~e;
    for (int k = 0; k < 40 && rv !== e; k++) spi(1'b1, ADDR_LOCK_STAT, 8'h00, rv);
    chk_val("lock status", {2'h0, e}, {2'h0, rv});
  endtask : wait_stat
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [6:0] a [11];
    logic [7:0] e [11];
    a = '{ADDR_CTRL, ADDR_SMP_LO, ADDR_SMP_HI, ADDR_STB_LO_WIN, ADDR_STB_HI, ADDR_ACT_SMP_LO,
      ADDR_ACT_SMP_HI, ADDR_ACT_STB_LO, ADDR_ACT_STB_HI, ADDR_LOCK_STAT, 7'h30};
    e = '{CTRL_RST, SMP_LO_RST, SMP_HI_RST, STB_LO_WIN_RST, STB_HI_RST, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00};
    for (int i = 0; i < 11; i++) rd_chk("reset register", a[i], e[i]);
    chk_val("fixed sample", 10'h0A7, smp);
    chk_val("fixed strobe", 10'h0A7, stb);
    chk_val("window", 10'h001, {6'h00, win});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fixed;
    run = 1'b0;
    wr(ADDR_SMP_HI, 8'h7F);
    wr(ADDR_STB_HI, 8'h05);
    wr(ADDR_STB_LO_WIN, 8'h32);
    wr(ADDR_ACT_SMP_LO, 8'hFF);
    chk_val("clamped sample", DELAY_MAX, smp);
    chk_val("strobe code", 10'h053, stb);
    chk_val("window", 10'h002, {6'h00, win});
    rd_chk("read-only write", ADDR_ACT_SMP_LO, 8'h00);
    rd_chk("strobe high", ADDR_STB_HI, 8'h05);
    wr(ADDR_SMP_HI, SMP_HI_RST);
    wr(ADDR_STB_HI, STB_HI_RST);
    wr(ADDR_STB_LO_WIN, STB_LO_WIN_RST);
    $display("t_fixed done");
  endtask : t_fixed
  task automatic t_search;
    mode = 2'h1;
    run = 1'b1;
    wr(ADDR_CTRL, 8'h03);
    rd_chk("search flag", ADDR_LOCK_STAT, 8'h04);
    rd_chk("actual before lock", ADDR_ACT_SMP_HI, 8'h00);
    for (int k = 0; k < 5000 && stb !== DELAY_MAX; k++) @(negedge i_clk);
    chk_val("search limit", DELAY_MAX, stb);
    chk_val("lines equal", DELAY_MAX, smp);
    mode = 2'h2;
    wait_stat(8'h09);
    rd_chk("actual sample high", ADDR_ACT_SMP_HI, 8'h60);
    rd_chk("actual sample low", ADDR_ACT_SMP_LO, 8'h00);
    rd_chk("actual strobe high", ADDR_ACT_STB_HI, 8'h60);
    rd_chk("actual strobe low", ADDR_ACT_STB_LO, 8'h00);
    $display("t_search done");
  endtask : t_search
  task automatic t_loss;
    mode = 2'h1;
    for (int k = 0; k < 400 && irq !== 1'b1; k++) @(negedge i_clk);
    @(negedge i_clk);
    chk_bit("relock irq", 1'b1, irq);
    chk_val("restart code", 10'h0A7, stb);
    wait_stat(8'h06);
    wr(ADDR_CTRL, 8'h07);
    wr(ADDR_CTRL, 8'h03);
    rd_chk("flags cleared", ADDR_LOCK_STAT, 8'h04);
    chk_bit("irq cleared", 1'b0, irq);
    // Early and late both low walk the lines down
    mode = 2'h0;
    repeat (40) @(negedge i_clk);
    held = stb;
    for (int k = 0; k < 40 && stb === held; k++) @(negedge i_clk);
    chk_val("step down strobe", held - 10'h001, stb);
    chk_val("step down sample", held - 10'h001, smp);
    $display("t_loss done");
  endtask : t_loss
  task automatic t_hold;
    wr(ADDR_CTRL, 8'h01);
    mode = 2'h2;
    wait_stat(8'h09);
    mode = 2'h1;
    wait_stat(8'h02);
    held = stb;
    repeat (100) @(negedge i_clk);
    chk_val("held delay", held, stb);
    chk_bit("no irq", 1'b0, irq);
    wr(ADDR_CTRL, 8'h02);
    rd_chk("disabled flags", ADDR_LOCK_STAT, 8'h00);
    rd_chk("disabled actual", ADDR_ACT_STB_HI, 8'h00);
    chk_val("fixed again", 10'h0A7, smp);
    // Strobe stopped so the start values stand still while checked
    run = 1'b0;
    wr(ADDR_SMP_LO, 8'h80);
    wr(ADDR_CTRL, 8'h01);
    chk_val("sample start", 10'h0A6, smp);
    chk_val("strobe start", 10'h0A7, stb);
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_SMP_LO, SMP_LO_RST);
    $display("t_hold done");
  endtask : t_hold
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    repeat (40000) @(posedge i_clk);
    err_count++;
    results();
  end
  initial begin
    i_rst = 1'b1;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    run = 1'b1;
    mode = 2'h2;
    rv = 8'h00;
    held = 10'h000;
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (5) @(negedge i_clk);
    t_reset();
    t_fixed();
    t_search();
    t_loss();
    t_hold();
    results();
  end
endmodule : rdl_data_receiver_delay_regs_tb_top
